// ### src/cms_pkg.sv
/*
 * constants and types for the carrier motion sequencer.
 * assumes one 40 MHz clock; sensors read 1 when light blocked.
 */
// Contract
// - one axis at a time; vertical homing first
// - middle blocked: descend to lower home
// - drop clear, rise block, add 7 mm
// - proximity blocked: go right until clear
// - then left until blocked: left reference
// - right past sensor 1, five more steps
// - left to sensor 1, centre on slit
// - nine stop positions per reservoir
// - seven patterns, all from home
// - start route from standby approach
// - start route from upper limit centre
// - transfer: up, across, down to mix lower
// - floor change only inside start/transfer
// - holding basket: via both floor homes
// - empty: homes, or reservoir 21 standby
// - mix stroke clamped to 10..30 mm
// - enhanced wash: immerse then lift clear
// - same basket: mix lower to lower centre
// - other basket: on to standby approach
// - temporary stop: halt at upper approach
package cms_pkg;
	localparam int CLK_HZ         = 40_000_000;
	localparam int STEP_PERIOD_US = 1000;
	localparam int STEP_DIV       = CLK_HZ / 1_000_000 * STEP_PERIOD_US;
	localparam int STEPS_PER_MM   = 8;
	localparam int HOME_RISE_MM   = 7;
	localparam int HOME_RISE      = HOME_RISE_MM * STEPS_PER_MM;
	localparam int POS1_EXTRA     = 5;
	localparam int MIX_MIN_MM     = 10;
	localparam int MIX_MAX_MM     = 30;
	localparam int MIX_CYCLES     = 4;
	localparam int RES_PER_FLOOR  = 14;
	localparam int FC_RES         = 21;
	localparam logic [15:0] SLIT_CENTRE = 16'h0010;
	localparam logic [15:0] X_FIRST     = 16'h0040;
	localparam logic [15:0] X_PITCH     = 16'h0100;
	localparam logic [15:0] X_APPROACH  = 16'h0030;
	localparam logic [15:0] Z_LOWER     = 16'h0200;
	localparam logic [15:0] Z_UPPER     = 16'h1000;
	localparam logic [15:0] Z_HOME      = 16'h0600;

	typedef enum logic [3:0] {
		stp_upper_ctr, stp_upper_app, stp_surface, stp_standby_ctr, stp_standby_app,
		stp_mix_upper, stp_mix_lower, stp_lower_ctr, stp_lower_app
	} cms_stop_t;

	typedef enum logic [2:0] {
		rt_to_start, rt_transfer, rt_floor, rt_mix, rt_wash, rt_release, rt_temp_stop, rt_home
	} cms_route_t;

	typedef struct packed {
		cms_route_t  route;
		logic [4:0]  start_res;
		logic [4:0]  end_res;
		logic        same_basket;
		logic [5:0]  mix_mm;
	} cms_cmd_t;

	typedef struct packed {
		logic upper_home;
		logic lower_home;
		logic middle;
		logic prox;
		logic pos1;
	} cms_sensor_t;

	typedef struct packed {
		logic z_step;
		logic z_up;
		logic x_step;
		logic x_right;
	} cms_motor_t;

	typedef struct packed {
		logic       valid;
		cms_stop_t  stop;
		logic [1:0] sel;
	} cms_leg_t;
endpackage

// ### src/cms_sequencer.sv
/*
 * carrier motion sequencer: homing, stop positions and route patterns.
 * assumes sensors synchronous-ish to clock_in; motor drivers take one
 * step per z_step/x_step pulse in the direction given beside it.
 */
`timescale 1ns/1ps
`default_nettype none
module cms_sequencer
	import cms_pkg::*;
#(
	parameter int STEP_DIV_P = STEP_DIV
)(
	input  wire logic        clock_in,
	input  wire logic        reset_in,
	input  wire logic        cmd_valid_in,
	input  wire cms_cmd_t    cmd_in,
	output logic             cmd_ready_out,
	input  wire cms_sensor_t sensor_in,
	output cms_motor_t       motor_out,
	output logic             busy_out,
	output logic             homed_out,
	output logic             done_out,
	output logic             refused_out
);
	typedef enum {
		st_idle, st_zh_seek, st_zh_drop, st_zh_rise, st_zh_lift,
		st_xh_clear, st_xh_left, st_xh_pos1, st_xh_extra, st_xh_back, st_xh_centre,
		st_leg, st_fc1, st_fc2, st_move, st_mix, st_done
	} cms_state_t;

	cms_sensor_t sm_q, s_q;
	cms_state_t  st_q, st_d, ret_q, ret_d;
	cms_cmd_t    cmd_q, cmd_d;
	cms_motor_t  mot_q, mot_d;
	cms_stop_t   stop_q, stop_d;
	logic [31:0] div_q, div_d;
	logic [15:0] cz_q, cz_d, cx_q, cx_d, tz_q, tz_d, tx_q, tx_d, cnt_q, cnt_d;
	logic [4:0]  res_q, res_d;
	logic [3:0]  mix_q, mix_d;
	logic [1:0]  idx_q, idx_d;
	logic        floor_q, floor_d, zfirst_q, zfirst_d, homed_q, homed_d;
	logic        done_q, done_d, ref_q, ref_d, fcsb_q, fcsb_d;
	logic        step_en, tfloor, home_hit;
	cms_leg_t    leg;
	logic [4:0]  tres;
	logic [15:0] stroke;

	// z offset of each stop above its floor base
	function automatic logic [15:0] stop_z(input cms_stop_t s);
		case (s)
			stp_upper_ctr, stp_upper_app:     return 16'h0500;
			stp_surface:                      return 16'h0300;
			stp_standby_ctr, stp_standby_app: return 16'h0280;
			stp_mix_upper:                    return 16'h0200;
			stp_mix_lower:                    return 16'h0100;
			default:                          return 16'h0080;
		endcase
	endfunction

	function automatic logic [15:0] zpos(input logic fl, input cms_stop_t s);
		return (fl ? Z_UPPER : Z_LOWER) + stop_z(s);
	endfunction

	// approach points sit beside the centre line
	function automatic logic [15:0] xpos(input logic [4:0] r, input cms_stop_t s);
		logic [4:0]  col;
		logic [15:0] x;
		col = (r >= 5'(RES_PER_FLOOR)) ? r - 5'(RES_PER_FLOOR) : r;
		x   = X_FIRST + 16'(col * X_PITCH);
		if (s == stp_upper_app || s == stp_standby_app || s == stp_lower_app)
			x = x + X_APPROACH;
		return x;
	endfunction

	// each pattern but rt_floor as a short list of stops; sel 0 current, 1 start, 2 end
	function automatic cms_leg_t route_leg(input cms_route_t rt, input logic [1:0] i,
			input logic same, input logic from_sb);
		cms_leg_t l;
		l = '{valid: 1'b0, stop: stp_upper_ctr, sel: 2'd0};
		case (rt)
			rt_to_start:
			begin
				l.sel = 2'd1;
				l.valid = (i < 2'd3);
				case (i)
					2'd0:    l.stop = from_sb ? stp_standby_app : stp_upper_app;
					2'd1:    l.stop = stp_lower_app;
					default: l.stop = stp_lower_ctr;
				endcase
			end
			rt_transfer:
			begin
				l.valid = (i < 2'd3);
				l.sel = (i == 2'd0) ? 2'd1 : 2'd2;
				l.stop = (i == 2'd2) ? stp_mix_lower : stp_upper_ctr;
			end
			rt_mix:
			begin
				l.valid = (i == 2'd0);
				l.stop = stp_mix_lower;
			end
			rt_wash:
			begin
				l.valid = (i < 2'd2);
				l.stop = (i == 2'd0) ? stp_lower_ctr : stp_upper_ctr;
			end
			rt_release:
			begin
				l.valid = same ? (i == 2'd0) : (i < 2'd3);
				case (i)
					2'd0:    l.stop = stp_lower_ctr;
					2'd1:    l.stop = stp_lower_app;
					default: l.stop = stp_standby_app;
				endcase
			end
			rt_temp_stop:
			begin
				l.valid = (i < 2'd2);
				l.stop = (i == 2'd0) ? stp_lower_ctr : stp_upper_app;
			end
			default: l.valid = 1'b0;
		endcase
		return l;
	endfunction

	// helpers for the current leg and the mix stroke
	always_comb
	begin
		leg = route_leg(cmd_q.route, idx_q, cmd_q.same_basket, stop_q == stp_standby_app);
		case (leg.sel)
			2'd1:    tres = cmd_q.start_res;
			2'd2:    tres = cmd_q.end_res;
			default: tres = res_q;
		endcase
		tfloor = (tres >= 5'(RES_PER_FLOOR));
		if (cmd_q.mix_mm < 6'(MIX_MIN_MM))
			stroke = 16'(MIX_MIN_MM * STEPS_PER_MM);
		else if (cmd_q.mix_mm > 6'(MIX_MAX_MM))
			stroke = 16'(MIX_MAX_MM * STEPS_PER_MM);
		else
			stroke = 16'(cmd_q.mix_mm) * 16'(STEPS_PER_MM);
		home_hit = s_q.lower_home | (zfirst_q & s_q.upper_home);
	end

	// step rate divider; one enable pulse per motor step
	always_comb
	begin
		step_en = (div_q == 32'(STEP_DIV_P - 1));
		div_d = step_en ? 32'h0 : div_q + 32'h1;
	end

	// sequencer next state; zfirst doubles as seek-up during homing
	always_comb
	begin
		st_d = st_q;
		ret_d = ret_q;
		cmd_d = cmd_q;
		mot_d = '0;
		stop_d = stop_q;
		cz_d = cz_q;
		cx_d = cx_q;
		tz_d = tz_q;
		tx_d = tx_q;
		cnt_d = cnt_q;
		res_d = res_q;
		mix_d = mix_q;
		idx_d = idx_q;
		floor_d = floor_q;
		zfirst_d = zfirst_q;
		homed_d = homed_q;
		fcsb_d = fcsb_q;
		done_d = 1'b0;
		ref_d = 1'b0;
		case (st_q)
			st_idle:
			if (cmd_valid_in)
			begin
				if (cmd_in.route == rt_home)
				begin
					cmd_d = cmd_in;
					homed_d = 1'b0;
					zfirst_d = ~s_q.middle;
					st_d = st_zh_seek;
				end
				else if (!homed_q || cmd_in.route == rt_floor)
					ref_d = 1'b1;
				else
				begin
					cmd_d = cmd_in;
					idx_d = 2'd0;
					mix_d = 4'd0;
					st_d = st_leg;
				end
			end
			st_zh_seek:
			if (home_hit)
			begin
				floor_d = ~s_q.lower_home;
				st_d = st_zh_drop;
			end
			else if (step_en)
				mot_d = '{z_step: 1'b1, z_up: zfirst_q, x_step: 1'b0, x_right: 1'b0};
			st_zh_drop:
			if (!(floor_q ? s_q.upper_home : s_q.lower_home))
				st_d = st_zh_rise;
			else if (step_en)
				mot_d = '{z_step: 1'b1, z_up: 1'b0, x_step: 1'b0, x_right: 1'b0};
			st_zh_rise:
			if (floor_q ? s_q.upper_home : s_q.lower_home)
			begin
				cnt_d = 16'(HOME_RISE);
				st_d = st_zh_lift;
			end
			else if (step_en)
				mot_d = '{z_step: 1'b1, z_up: 1'b1, x_step: 1'b0, x_right: 1'b0};
			st_zh_lift:
			if (cnt_q == 16'h0)
			begin
				cz_d = (floor_q ? Z_UPPER : Z_LOWER) + Z_HOME;
				st_d = st_xh_clear;
			end
			else if (step_en)
			begin
				mot_d = '{z_step: 1'b1, z_up: 1'b1, x_step: 1'b0, x_right: 1'b0};
				cnt_d = cnt_q - 16'h1;
			end
			st_xh_clear:
			if (!s_q.prox)
				st_d = st_xh_left;
			else if (step_en)
				mot_d = '{z_step: 1'b0, z_up: 1'b0, x_step: 1'b1, x_right: 1'b1};
			st_xh_left:
			if (s_q.prox)
				st_d = st_xh_pos1;
			else if (step_en)
				mot_d = '{z_step: 1'b0, z_up: 1'b0, x_step: 1'b1, x_right: 1'b0};
			st_xh_pos1:
			if (!s_q.pos1)
			begin
				cnt_d = 16'(POS1_EXTRA);
				st_d = st_xh_extra;
			end
			else if (step_en)
				mot_d = '{z_step: 1'b0, z_up: 1'b0, x_step: 1'b1, x_right: 1'b1};
			st_xh_extra:
			if (cnt_q == 16'h0)
				st_d = st_xh_back;
			else if (step_en)
			begin
				mot_d = '{z_step: 1'b0, z_up: 1'b0, x_step: 1'b1, x_right: 1'b1};
				cnt_d = cnt_q - 16'h1;
			end
			st_xh_back:
			if (s_q.pos1)
			begin
				cnt_d = {1'b0, cnt_q[15:1]} + SLIT_CENTRE;
				st_d = st_xh_centre;
			end
			else if (step_en)
			begin
				mot_d = '{z_step: 1'b0, z_up: 1'b0, x_step: 1'b1, x_right: 1'b0};
				cnt_d = cnt_q + 16'h1;
			end
			st_xh_centre:
			if (cnt_q == 16'h0)
			begin
				cx_d = 16'h0;
				homed_d = 1'b1;
				stop_d = stp_upper_ctr;
				st_d = st_done;
			end
			else if (step_en)
			begin
				mot_d = '{z_step: 1'b0, z_up: 1'b0, x_step: 1'b1, x_right: 1'b1};
				cnt_d = cnt_q - 16'h1;
			end
			st_leg:
			if (!leg.valid)
				st_d = (cmd_q.route == rt_mix) ? st_mix : st_done;
			else if (tfloor != floor_q)
				st_d = st_fc1;
			else
			begin
				tz_d = zpos(floor_q, leg.stop);
				tx_d = xpos(tres, leg.stop);
				zfirst_d = (zpos(floor_q, leg.stop) > cz_q);
				stop_d = leg.stop;
				res_d = tres;
				idx_d = idx_q + 2'd1;
				ret_d = st_leg;
				st_d = st_move;
			end
			st_fc1:
			begin
				fcsb_d = (cmd_q.route != rt_transfer) && (stop_q == stp_standby_app);
				if ((cmd_q.route != rt_transfer) && (stop_q == stp_standby_app))
				begin
					tz_d = zpos(floor_q, stp_standby_ctr);
					tx_d = xpos(5'(FC_RES), stp_standby_ctr);
				end
				else
					tz_d = (floor_q ? Z_UPPER : Z_LOWER) + Z_HOME;
				zfirst_d = 1'b1;
				ret_d = st_fc2;
				st_d = st_move;
			end
			st_fc2:
			begin
				floor_d = ~floor_q;
				tz_d = fcsb_q ? zpos(~floor_q, stp_standby_ctr) : (floor_q ? Z_LOWER : Z_UPPER) + Z_HOME;
				stop_d = fcsb_q ? stp_standby_ctr : stp_upper_ctr;
				zfirst_d = 1'b1;
				ret_d = st_leg;
				st_d = st_move;
			end
			st_move:
			if (step_en)
			begin
				// rising goes before travel, travel before descent
				if (zfirst_q && cz_q != tz_q || cx_q == tx_q && cz_q != tz_q)
				begin
					mot_d = '{z_step: 1'b1, z_up: tz_q > cz_q, x_step: 1'b0, x_right: 1'b0};
					cz_d = (tz_q > cz_q) ? cz_q + 16'h1 : cz_q - 16'h1;
				end
				else if (cx_q != tx_q)
				begin
					mot_d = '{z_step: 1'b0, z_up: 1'b0, x_step: 1'b1, x_right: tx_q > cx_q};
					cx_d = (tx_q > cx_q) ? cx_q + 16'h1 : cx_q - 16'h1;
				end
				else
					st_d = ret_q;
			end
			st_mix:
			if (mix_q == 4'(2 * MIX_CYCLES))
				st_d = st_done;
			else
			begin
				tz_d = zpos(floor_q, stp_mix_lower) + (mix_q[0] ? 16'h0 : stroke);
				zfirst_d = 1'b1;
				mix_d = mix_q + 4'd1;
				ret_d = st_mix;
				st_d = st_move;
			end
			st_done:
			begin
				done_d = 1'b1;
				st_d = st_idle;
			end
			default: st_d = st_idle;
		endcase
	end

	// registers; sensors pass two flops before use
	always_ff @(posedge clock_in)
	begin
		sm_q <= sensor_in;
		s_q <= sm_q;
		if (reset_in)
		begin
			st_q <= st_idle;
			ret_q <= st_idle;
			cmd_q <= '0;
			mot_q <= '0;
			stop_q <= stp_upper_ctr;
			div_q <= 32'h0;
			cz_q <= 16'h0;
			cx_q <= 16'h0;
			tz_q <= 16'h0;
			tx_q <= 16'h0;
			cnt_q <= 16'h0;
			res_q <= 5'h0;
			mix_q <= 4'h0;
			idx_q <= 2'h0;
			floor_q <= 1'b0;
			zfirst_q <= 1'b0;
			homed_q <= 1'b0;
			fcsb_q <= 1'b0;
			done_q <= 1'b0;
			ref_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			ret_q <= ret_d;
			cmd_q <= cmd_d;
			mot_q <= mot_d;
			stop_q <= stop_d;
			div_q <= div_d;
			cz_q <= cz_d;
			cx_q <= cx_d;
			tz_q <= tz_d;
			tx_q <= tx_d;
			cnt_q <= cnt_d;
			res_q <= res_d;
			mix_q <= mix_d;
			idx_q <= idx_d;
			floor_q <= floor_d;
			zfirst_q <= zfirst_d;
			homed_q <= homed_d;
			fcsb_q <= fcsb_d;
			done_q <= done_d;
			ref_q <= ref_d;
		end
	end

	assign cmd_ready_out = (st_q == st_idle);
	assign motor_out = mot_q;
	assign busy_out = (st_q != st_idle);
	assign homed_out = homed_q;
	assign done_out = done_q;
	assign refused_out = ref_q;
endmodule
`default_nettype wire

// ### bench/cms_sequencer_properties.sv
/*
 * port properties of the carrier motion sequencer.
 * assumes a bind onto cms_sequencer with the same step divider.
 */
`timescale 1ns/1ps
`default_nettype none
module cms_sequencer_checker
	import cms_pkg::*;
#(
	parameter int STEP_DIV_P = STEP_DIV
)(
	input wire logic        clock_in,
	input wire logic        reset_in,
	input wire logic        cmd_valid_in,
	input wire cms_cmd_t    cmd_in,
	input wire logic        cmd_ready_out,
	input wire cms_sensor_t sensor_in,
	input wire cms_motor_t  motor_out,
	input wire logic        busy_out,
	input wire logic        homed_out,
	input wire logic        done_out,
	input wire logic        refused_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (reset_in);

	// a command is taken only when the port is ready
	wire taken = cmd_valid_in && cmd_ready_out;
	wire stepping = motor_out.z_step || motor_out.x_step;

	// gap of three assumes the divider is at least four, as in any real build
	a_axes_exclusive: assert property (!(motor_out.z_step && motor_out.x_step)) else $error("both axes stepped");
	a_step_spacing: assert property (stepping |=> !stepping [*3]) else $error("steps too close");
	a_floor_refused: assert property (taken && cmd_in.route == rt_floor |=> refused_out) else $error("floor cmd taken");
	a_unhomed_refused: assert property (taken && !homed_out && cmd_in.route != rt_home |=> refused_out)
		else $error("move before homing");
	a_ready_idle: assert property (cmd_ready_out == !busy_out) else $error("ready not idle");
	a_done_single: assert property (done_out |=> !done_out) else $error("done too long");
	a_accept_busy: assert property (taken && homed_out && cmd_in.route != rt_floor |=> busy_out && !refused_out)
		else $error("route not started");
	a_home_restart: assert property (taken && cmd_in.route == rt_home |-> ##[1:2] !homed_out)
		else $error("homed kept on rehome");
	a_idle_still: assert property (!busy_out && !$past(busy_out) |-> !stepping) else $error("step while idle");
	a_refuse_ready: assert property (refused_out |-> cmd_ready_out) else $error("refusal dropped ready");
endmodule
`default_nettype wire

// ### bench/cms_carrier_model.sv
/*
 * carrier, motor drivers and photo interrupters seen by the sequencer.
 * assumes one step per pulse; sensors read 1 when light is blocked.
 */
`timescale 1ns/1ps
`default_nettype none
module cms_carrier_model
	import cms_pkg::*;
#(
	parameter int Z_START  = 80,
	parameter int X_START  = 8,
	parameter int LOWER_LO = 40,
	parameter int UPPER_LO = 140,
	parameter int BAND     = 8,
	parameter int MID_LO   = 60,
	parameter int MID_HI   = 120,
	parameter int PROX_LIM = 16,
	parameter int POS1_LIM = 24
)(
	input wire logic        clock_in,
	input wire logic        reset_in,
	input wire cms_motor_t  motor_in,
	output cms_sensor_t     sensor_out,
	output int              z_pos_out,
	output int              x_pos_out,
	output int              z_at_x_out
);
	logic x_moved;

	// flags are pure functions of position, so they change the cycle after a step
	assign sensor_out.lower_home = z_pos_out >= LOWER_LO && z_pos_out < LOWER_LO + BAND;
	assign sensor_out.upper_home = z_pos_out >= UPPER_LO && z_pos_out < UPPER_LO + BAND;
	assign sensor_out.middle     = z_pos_out >= MID_LO && z_pos_out < MID_HI;
	assign sensor_out.prox       = x_pos_out < PROX_LIM;
	assign sensor_out.pos1       = x_pos_out < POS1_LIM;

	// position follows each pulse; z at the first x pulse shows axis order
	always_ff @(posedge clock_in)
	begin
		if (reset_in)
		begin
			z_pos_out <= Z_START;
			x_pos_out <= X_START;
			x_moved   <= 1'b0;
		end
		else
		begin
			if (motor_in.z_step)
				z_pos_out <= z_pos_out + (motor_in.z_up ? 1 : -1);
			if (motor_in.x_step)
			begin
				x_pos_out <= x_pos_out + (motor_in.x_right ? 1 : -1);
				if (!x_moved)
					z_at_x_out <= z_pos_out;
				x_moved <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ### bench/test_cms_sequencer.sv
/*
 * self-checking bench for the carrier motion sequencer.
 * assumes the carrier model on the motor side and a short step divider.
 */
`timescale 1ns/1ps
`default_nettype none
`define CMS_CHECK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_cms_sequencer;
	import cms_pkg::*;
	localparam int DIV   = 4;
	localparam int LOW   = 40;
	localparam int P1    = 24;
	localparam int Z_EXP = LOW + HOME_RISE;
	localparam int X_EXP = P1 - 1 + (POS1_EXTRA + 1) / 2 + int'(SLIT_CENTRE);
	logic        clock_in     = 1'b0;
	logic        reset_in     = 1'b1;
	logic        cmd_valid_in = 1'b0;
	cms_cmd_t    cmd_in       = '0;
	cms_sensor_t sensor;
	cms_motor_t  motor;
	logic        ready, busy, homed, done, refused, got_ref;
	int          z_pos, x_pos, z_at_x, x_home, zmin, zmax, a, b, c, mm;
	int          n_mismatch   = 0;
	int          checks_done  = 0;
	logic [31:0] rng          = 32'h0000005a;

	always #12.5 clock_in = ~clock_in;

	cms_sequencer #(.STEP_DIV_P(DIV)) dut (.clock_in(clock_in), .reset_in(reset_in), .cmd_valid_in(cmd_valid_in),
		.cmd_in(cmd_in), .cmd_ready_out(ready), .sensor_in(sensor), .motor_out(motor), .busy_out(busy),
		.homed_out(homed), .done_out(done), .refused_out(refused));
	cms_carrier_model #(.LOWER_LO(LOW), .POS1_LIM(P1)) carrier (.clock_in(clock_in), .reset_in(reset_in),
		.motor_in(motor), .sensor_out(sensor), .z_pos_out(z_pos), .x_pos_out(x_pos), .z_at_x_out(z_at_x));

	// xorshift keeps runs repeatable
	function automatic logic [31:0] next_rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	// x of a stop, counted from horizontal home
	function automatic int x_stop(input int col, input bit app);
		return X_FIRST + col * X_PITCH + (app ? X_APPROACH : 0);
	endfunction

	// mix excursion after the stroke clamp
	function automatic int stroke(input int m);
		return (m < MIX_MIN_MM ? MIX_MIN_MM : (m > MIX_MAX_MM ? MIX_MAX_MM : m)) * STEPS_PER_MM;
	endfunction

	task automatic close_out();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// one command, then wait bounded for done or refusal while tracking z span
	task automatic send(input cms_route_t r, input int s, input int e, input bit same, input int m);
		int i;
		cmd_in = '{r, 5'(s), 5'(e), same, 6'(m)};
		cmd_valid_in = 1'b1;
		@(negedge clock_in);
		cmd_valid_in = 1'b0;
		for (i = 0; i < 80000 && done !== 1'b1 && refused !== 1'b1; i++)
		begin
			zmin = z_pos < zmin ? z_pos : zmin;
			zmax = z_pos > zmax ? z_pos : zmax;
			@(negedge clock_in);
		end
		if (i == 80000)
		begin
			n_mismatch++;
			close_out();
		end
		got_ref = refused;
		@(negedge clock_in);
	endtask

	initial
	begin
		repeat (2) @(negedge clock_in);
		reset_in = 1'b0;
		repeat (3) @(negedge clock_in);
		`CMS_CHECK({ready, busy, homed, done, refused, motor}, 9'h100)
		send(rt_to_start, 1, 0, 0, 0);
		`CMS_CHECK({got_ref, x_pos}, {1'b1, 32'd8})
		// vertical then horizontal homing against the sensor geometry
		send(rt_home, 0, 0, 0, 0);
		`CMS_CHECK({got_ref, homed}, 2'b01)
		`CMS_CHECK(z_pos, Z_EXP)
		`CMS_CHECK(z_at_x, Z_EXP)
		`CMS_CHECK(x_pos, X_EXP)
		x_home = x_pos;
		send(rt_floor, 0, 14, 0, 0);
		`CMS_CHECK(got_ref, 1'b1)
		a = next_rnd() % 3;
		b = next_rnd() % 3;
		c = next_rnd() % 3;
		send(rt_to_start, a, 0, 0, 0);
		`CMS_CHECK(x_pos - x_home, x_stop(a, 0))
		send(rt_transfer, a, b, 0, 0);
		`CMS_CHECK(x_pos - x_home, x_stop(b, 0))
		// short stroke corner first, then a random one that may clamp high
		for (int k = 0; k < 2; k++)
		begin
			mm = k == 0 ? 5 : next_rnd() % 64;
			zmin = z_pos;
			zmax = z_pos;
			send(rt_mix, b, b, 0, mm);
			`CMS_CHECK(zmax - zmin, stroke(mm))
		end
		send(rt_release, b, b, 1, 0);
		`CMS_CHECK(x_pos - x_home, x_stop(b, 0))
		send(rt_release, b, b, 0, 0);
		`CMS_CHECK(x_pos - x_home, x_stop(b, 1))
		send(rt_to_start, c, 0, 0, 0);
		`CMS_CHECK(x_pos - x_home, x_stop(c, 0))
		send(rt_temp_stop, c, c, 0, 0);
		`CMS_CHECK(x_pos - x_home, x_stop(c, 1))
		send(rt_wash, c, c, 0, 0);
		`CMS_CHECK({got_ref, homed}, 2'b01)
		`CMS_CHECK(x_pos - x_home, x_stop(c, 0))
		// holding a basket across floors: first upper reservoir is column 0
		send(rt_transfer, c, RES_PER_FLOOR, 0, 0);
		`CMS_CHECK(got_ref, 1'b0)
		`CMS_CHECK(x_pos - x_home, x_stop(0, 0))
		close_out();
	end
endmodule
bind cms_sequencer cms_sequencer_checker #(.STEP_DIV_P(STEP_DIV_P)) chk (.clock_in(clock_in), .reset_in(reset_in),
	.cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out), .sensor_in(sensor_in),
	.motor_out(motor_out), .busy_out(busy_out), .homed_out(homed_out), .done_out(done_out),
	.refused_out(refused_out));
`default_nettype wire
